// File: rtl/pxs_map.svh
// Register offsets, field positions, reset values and timing constants of the proximity block.
// Included by every design file that needs them; it holds definitions only.
`ifndef PXS_MAP_SVH
`define PXS_MAP_SVH
`define PXS_OFS_ENABLE      5'h00
`define PXS_OFS_ADC_TIME    5'h02
`define PXS_OFS_WAIT_TIME   5'h03
`define PXS_OFS_LOW_LSB     5'h08
`define PXS_OFS_LOW_MSB     5'h09
`define PXS_OFS_HIGH_LSB    5'h0a
`define PXS_OFS_HIGH_MSB    5'h0b
`define PXS_OFS_PERSIST     5'h0c
`define PXS_OFS_CONFIG      5'h0d
`define PXS_OFS_PULSES      5'h0e
`define PXS_OFS_CONTROL     5'h0f
`define PXS_OFS_REVISION    5'h11
`define PXS_OFS_PART_ID     5'h12
`define PXS_OFS_FLAGS       5'h13
`define PXS_OFS_RES_LSB     5'h18
`define PXS_OFS_RES_MSB     5'h19
`define PXS_OFS_SHIFT       5'h1e
`define PXS_BIT_OSC_ON      0
`define PXS_BIT_MEAS_EN     2
`define PXS_BIT_WAIT_EN     3
`define PXS_BIT_IRQ_OE      5
`define PXS_BIT_SAI         6
`define PXS_ENABLE_MASK     8'h6d
`define PXS_BIT_LONG_WAIT   1
`define PXS_FLAG_VALID      0
`define PXS_FLAG_IRQ        5
`define PXS_FLAG_SAT        6
`define PXS_CMD_SELECT      7
`define PXS_TYPE_REPEAT     2'h0
`define PXS_TYPE_AUTO_INC   2'h1
`define PXS_TYPE_SPECIAL    2'h3
`define PXS_SF_IRQ_CLEAR    5'h05
`define PXS_RST_TIME        8'hff
`define PXS_RST_ZERO        8'h00
`define PXS_CLK_NS          100
`define PXS_UNIT_NS         2730000
`define PXS_LED_ON_NS       7300
`define PXS_LED_OFF_NS      8700
`define PXS_UNIT_CYC        ((`PXS_UNIT_NS + `PXS_CLK_NS - 1) / `PXS_CLK_NS)
`define PXS_LED_ON_CYC      ((`PXS_LED_ON_NS + `PXS_CLK_NS - 1) / `PXS_CLK_NS)
`define PXS_LED_OFF_CYC     ((`PXS_LED_OFF_NS + `PXS_CLK_NS - 1) / `PXS_CLK_NS)
`define PXS_LONG_MULT       4'd12
`define PXS_UNITS_FULL      9'h100
`endif

// File: rtl/pxs_pkg.sv
// Types shared by the proximity sequencer and its serial link front end.
// Assumes the constants of pxs_map.svh are included where numbers are needed.
package pxs_pkg;
  typedef enum logic [2:0] {
    PXS_SLEEP, PXS_IDLE, PXS_INIT, PXS_ACCUM, PXS_PWAIT, PXS_ADC, PXS_WAIT
  } pxs_seq_t;

  typedef enum logic [2:0] {
    PXS_LK_IDLE, PXS_LK_ADDR, PXS_LK_AACK, PXS_LK_WR, PXS_LK_WACK, PXS_LK_RD, PXS_LK_RACK,
    PXS_LK_HOLD
  } pxs_link_t;

  typedef enum logic {PXS_EV_WRITE, PXS_EV_READ} pxs_ev_t;

  typedef struct packed {
    pxs_ev_t    kind;
    logic       first;
    logic [7:0] data;
  } pxs_req_t;
endpackage : pxs_pkg

// File: rtl/pxs_i2c_link.sv
// Serial slave front end on the link clock: bit timing, address match, acknowledge.
// Each data byte becomes a toggle request to the system domain; the clock line is held low
// until the system side toggles back, so no byte is lost across the crossing.
`include "pxs_map.svh"
module pxs_i2c_link
  import pxs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h4c
) (
  input  wire logic       link_clk,
  input  wire logic       rst,
  input  wire logic       scl_i,
  output      logic       scl_o,
  output      logic       scl_oe,
  input  wire logic       sda_i,
  output      logic       sda_o,
  output      logic       sda_oe,
  output      logic       req_tgl,
  output      pxs_req_t   req,
  input  wire logic       ack_tgl,
  input  wire logic [7:0] rd_data
);
  logic [1:0] rst_sync;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [2:0] ack_s;
  pxs_link_t  st;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic       is_rd;
  logic       first;

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  always_ff @(posedge link_clk) begin
    rst_sync <= {rst_sync[0], rst};
    scl_s    <= {scl_s[1:0], scl_i};
    sda_s    <= {sda_s[1:0], sda_i};
    ack_s    <= {ack_s[1:0], ack_tgl};
  end

  wire lrst     = rst_sync[1];
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start_c  = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  wire stop_c   = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
  wire ack_ev   = ack_s[1] ^ ack_s[2];

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      st      <= PXS_LK_IDLE;
      cnt     <= 4'h0;
      sh      <= 8'h00;
      is_rd   <= 1'b0;
      first   <= 1'b0;
      sda_oe  <= 1'b0;
      scl_oe  <= 1'b0;
      req_tgl <= 1'b0;
      req     <= '0;
    end else if (start_c) begin
      st     <= PXS_LK_ADDR;
      cnt    <= 4'h0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (stop_c) begin
      st     <= PXS_LK_IDLE;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      unique case (st)
        PXS_LK_IDLE: ;
        PXS_LK_ADDR, PXS_LK_WR: begin
          if (scl_rise) begin
            sh  <= {sh[6:0], sda_s[1]};
            cnt <= cnt + 4'h1;
          end else if (scl_fall && cnt == 4'h8) begin
            cnt <= 4'h0;
            if (st == PXS_LK_WR) begin
              req     <= '{kind: PXS_EV_WRITE, first: first, data: sh};
              req_tgl <= ~req_tgl;
              first   <= 1'b0;
              scl_oe  <= 1'b1;
              st      <= PXS_LK_HOLD;
            end else if (sh[7:1] == SLAVE_ADDR) begin
              is_rd  <= sh[0];
              first  <= 1'b1;
              sda_oe <= 1'b1;
              st     <= PXS_LK_AACK;
            end else begin
              st <= PXS_LK_IDLE;
            end
          end
        end
        PXS_LK_AACK, PXS_LK_WACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            cnt    <= 4'h0;
            if (is_rd) begin
              req     <= '{kind: PXS_EV_READ, first: 1'b0, data: 8'h00};
              req_tgl <= ~req_tgl;
              scl_oe  <= 1'b1;
              st      <= PXS_LK_HOLD;
            end else begin
              st <= PXS_LK_WR;
            end
          end
        end
        PXS_LK_HOLD: begin
          if (ack_ev) begin
            scl_oe <= 1'b0;
            if (is_rd) begin
              sh     <= rd_data;
              sda_oe <= ~rd_data[7];
              st     <= PXS_LK_RD;
            end else begin
              sda_oe <= 1'b1;
              st     <= PXS_LK_WACK;
            end
          end
        end
        PXS_LK_RD: begin
          if (scl_fall) begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h7) begin
              sda_oe <= 1'b0;
              st     <= PXS_LK_RACK;
            end else begin
              sh     <= {sh[6:0], 1'b0};
              sda_oe <= ~sh[6];
            end
          end
        end
        PXS_LK_RACK: begin
          if (scl_rise && sda_s[1]) begin
            st <= PXS_LK_IDLE;
          end else if (scl_fall) begin
            // The bit count restarts here, or every byte after the first would run long.
            cnt     <= 4'h0;
            req     <= '{kind: PXS_EV_READ, first: 1'b0, data: 8'h00};
            req_tgl <= ~req_tgl;
            scl_oe  <= 1'b1;
            st      <= PXS_LK_HOLD;
          end
        end
      endcase
    end
  end
endmodule : pxs_i2c_link

// File: rtl/pxs_top.sv
// Proximity measurement sequencer with threshold interrupt and register file.
// Assumes the analog front end delivers adc_result and adc_saturated on sys_clk, and
// the serial link pins are resolved as open-drain wires outside this design.
`include "pxs_map.svh"
module pxs_top
  import pxs_pkg::*;
#(
  parameter int         UNIT_CYCLES = `PXS_UNIT_CYC,
  parameter logic [6:0] SLAVE_ADDR  = 7'h4c,
  parameter logic [7:0] REV_CODE    = 8'h01, // Value is arbitrary.
  parameter logic [7:0] PART_CODE   = 8'h5a  // Value is arbitrary.
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        link_clk,
  input  wire logic        scl_i,
  output      logic        scl_o,
  output      logic        scl_oe,
  input  wire logic        sda_i,
  output      logic        sda_o,
  output      logic        sda_oe,
  input  wire logic [15:0] adc_result,
  input  wire logic        adc_saturated,
  output      logic        led_drive,
  output      logic        adc_busy,
  output      logic        irq_n
);
  pxs_req_t    req;
  logic        req_tgl;
  logic [2:0]  req_s;
  logic        ack_tgl;
  logic [7:0]  rd_data;
  logic [7:0]  rd_mux;
  logic [4:0]  pointer;
  logic        auto_inc;
  logic [7:0]  function_enable;
  logic [7:0]  adc_time_setting;
  logic [7:0]  wait_time_setting;
  logic [15:0] low_limit;
  logic [15:0] high_limit;
  logic [7:0]  persistence_filter;
  logic [7:0]  configuration;
  logic [7:0]  led_pulse_count;
  logic [7:0]  gain_drive_control;
  logic [7:0]  result_shift;
  logic [15:0] proximity_result;
  logic        irq_flag;
  logic        saturation_flag;
  logic        result_valid;
  logic [3:0]  persist_cnt;
  pxs_seq_t    st;
  pxs_seq_t    next_st;
  logic [14:0] cyc;
  logic [11:0] units;
  logic [7:0]  pulses;
  logic        seq_done;
  logic        oor;
  logic        irq_set;

  pxs_i2c_link #(
    .SLAVE_ADDR (SLAVE_ADDR)
  ) u_link (
    .link_clk (link_clk),
    .rst      (rst),
    .scl_i    (scl_i),
    .scl_o    (scl_o),
    .scl_oe   (scl_oe),
    .sda_i    (sda_i),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .req_tgl  (req_tgl),
    .req      (req),
    .ack_tgl  (ack_tgl),
    .rd_data  (rd_data)
  );

  // The payload is held by the link side until the acknowledge returns, so it is
  // stable whenever the synchronised toggle shows a new request.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_s <= 3'h0;
    end else begin
      req_s <= {req_s[1:0], req_tgl};
    end
  end

  wire req_ev   = req_s[1] ^ req_s[2];
  wire is_cmd   = req.kind == PXS_EV_WRITE && req.first && req.data[`PXS_CMD_SELECT];
  wire wr_en    = req_ev && req.kind == PXS_EV_WRITE && !is_cmd;
  wire sf_clear = req_ev && is_cmd && req.data[6:5] == `PXS_TYPE_SPECIAL
                  && req.data[4:0] == `PXS_SF_IRQ_CLEAR;

  wire osc_on   = function_enable[`PXS_BIT_OSC_ON];
  wire meas_en  = function_enable[`PXS_BIT_MEAS_EN];
  wire wait_en  = function_enable[`PXS_BIT_WAIT_EN];
  wire sleep_after_irq      = function_enable[`PXS_BIT_SAI];

  always_comb begin
    unique case (pointer)
      `PXS_OFS_ENABLE:    rd_mux = function_enable;
      `PXS_OFS_ADC_TIME:  rd_mux = adc_time_setting;
      `PXS_OFS_WAIT_TIME: rd_mux = wait_time_setting;
      `PXS_OFS_LOW_LSB:   rd_mux = low_limit[7:0];
      `PXS_OFS_LOW_MSB:   rd_mux = low_limit[15:8];
      `PXS_OFS_HIGH_LSB:  rd_mux = high_limit[7:0];
      `PXS_OFS_HIGH_MSB:  rd_mux = high_limit[15:8];
      `PXS_OFS_PERSIST:   rd_mux = persistence_filter;
      `PXS_OFS_CONFIG:    rd_mux = configuration;
      `PXS_OFS_PULSES:    rd_mux = led_pulse_count;
      `PXS_OFS_CONTROL:   rd_mux = gain_drive_control;
      `PXS_OFS_REVISION:  rd_mux = REV_CODE;
      `PXS_OFS_PART_ID:   rd_mux = PART_CODE;
      `PXS_OFS_FLAGS:     rd_mux = {1'b0, saturation_flag, irq_flag, 4'h0, result_valid};
      `PXS_OFS_RES_LSB:   rd_mux = proximity_result[7:0];
      `PXS_OFS_RES_MSB:   rd_mux = proximity_result[15:8];
      `PXS_OFS_SHIFT:     rd_mux = result_shift;
      default:            rd_mux = 8'h00;
    endcase
  end

  // Pointer, command decode and read return; every request is answered once.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pointer  <= 5'h00;
      auto_inc <= 1'b0;
      ack_tgl  <= 1'b0;
      rd_data  <= 8'h00;
    end else if (req_ev) begin
      ack_tgl <= ~ack_tgl;
      if (req.kind == PXS_EV_READ) begin
        rd_data <= rd_mux;
        if (auto_inc) begin
          pointer <= pointer + 5'h01;
        end
      end else if (is_cmd) begin
        // Reserved type and special functions leave the pointer where it was.
        if (req.data[6:5] == `PXS_TYPE_REPEAT || req.data[6:5] == `PXS_TYPE_AUTO_INC) begin
          pointer  <= req.data[4:0];
          auto_inc <= req.data[6:5] == `PXS_TYPE_AUTO_INC;
        end
      end else if (auto_inc) begin
        pointer <= pointer + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      function_enable    <= `PXS_RST_ZERO;
      adc_time_setting   <= `PXS_RST_TIME;
      wait_time_setting  <= `PXS_RST_TIME;
      low_limit          <= {`PXS_RST_ZERO, `PXS_RST_ZERO};
      high_limit         <= {`PXS_RST_ZERO, `PXS_RST_ZERO};
      persistence_filter <= `PXS_RST_ZERO;
      configuration      <= `PXS_RST_ZERO;
      led_pulse_count    <= `PXS_RST_ZERO;
      gain_drive_control <= `PXS_RST_ZERO;
      result_shift       <= `PXS_RST_ZERO;
    end else if (wr_en) begin
      unique case (pointer)
        `PXS_OFS_ENABLE:    function_enable <= req.data & `PXS_ENABLE_MASK;
        `PXS_OFS_ADC_TIME:  adc_time_setting <= req.data;
        `PXS_OFS_WAIT_TIME: wait_time_setting <= req.data;
        `PXS_OFS_LOW_LSB:   low_limit[7:0] <= req.data;
        `PXS_OFS_LOW_MSB:   low_limit[15:8] <= req.data;
        `PXS_OFS_HIGH_LSB:  high_limit[7:0] <= req.data;
        `PXS_OFS_HIGH_MSB:  high_limit[15:8] <= req.data;
        `PXS_OFS_PERSIST:   persistence_filter <= req.data;
        `PXS_OFS_CONFIG:    configuration <= req.data;
        `PXS_OFS_PULSES:    led_pulse_count <= req.data;
        `PXS_OFS_CONTROL:   gain_drive_control <= req.data;
        `PXS_OFS_SHIFT:     result_shift <= req.data;
        default: ;
      endcase
    end
  end

  wire        unit_end   = cyc == 15'(UNIT_CYCLES - 1);
  wire [11:0] adc_units  = {3'h0, 9'(`PXS_UNITS_FULL - {1'b0, adc_time_setting})};
  wire [8:0]  wait_base  = 9'(`PXS_UNITS_FULL - {1'b0, wait_time_setting});
  wire [11:0] wait_units = configuration[`PXS_BIT_LONG_WAIT] ?
                           12'({3'h0, wait_base} * `PXS_LONG_MULT) : {3'h0, wait_base};
  wire        led_last   = !led_drive && cyc == 15'(`PXS_LED_OFF_CYC - 1);

  always_comb begin
    unique case (st)
      PXS_INIT, PXS_PWAIT: seq_done = unit_end;
      PXS_ACCUM: seq_done = led_pulse_count == 8'h00
                            || (led_last && pulses == led_pulse_count - 8'h01);
      PXS_ADC:   seq_done = unit_end && units == adc_units - 12'h001;
      PXS_WAIT:  seq_done = unit_end && units == wait_units - 12'h001;
      default:   seq_done = 1'b0;
    endcase
  end

  wire adc_done = st == PXS_ADC && seq_done;
  // Low side is tested first; an inverted window never reports the high side.
  assign oor     = adc_result < low_limit
                   || (low_limit <= high_limit && adc_result > high_limit);
  assign irq_set = adc_done && oor
                   && {1'b0, persist_cnt} + 5'h01 >= {1'b0, persistence_filter[3:0]};

  always_comb begin
    next_st = st;
    unique case (st)
      PXS_SLEEP: if (req_ev) next_st = PXS_IDLE;
      PXS_IDLE:  if (!osc_on) next_st = PXS_SLEEP; else if (meas_en) next_st = PXS_INIT;
      PXS_INIT:  if (seq_done) next_st = PXS_ACCUM;
      PXS_ACCUM: if (seq_done) next_st = PXS_PWAIT;
      PXS_PWAIT: if (seq_done) next_st = PXS_ADC;
      PXS_ADC: begin
        if (seq_done) begin
          if (irq_set && sleep_after_irq) next_st = PXS_SLEEP;
          else if (wait_en) next_st = PXS_WAIT;
          else next_st = PXS_IDLE;
        end
      end
      PXS_WAIT:  if (seq_done) next_st = PXS_IDLE;
    endcase
    // Dropping either enable abandons the cycle rather than finishing a stale one.
    if (st != PXS_SLEEP && st != PXS_IDLE && (!osc_on || !meas_en)) next_st = PXS_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st       <= PXS_SLEEP;
      adc_busy <= 1'b0;
    end else begin
      st       <= next_st;
      adc_busy <= next_st == PXS_ADC;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || st != next_st) begin
      cyc       <= 15'h0000;
      units     <= 12'h000;
      pulses    <= 8'h00;
      led_drive <= !rst && next_st == PXS_ACCUM && led_pulse_count != 8'h00;
    end else if (st == PXS_ACCUM) begin
      cyc <= cyc + 15'h0001;
      if (led_drive && cyc == 15'(`PXS_LED_ON_CYC - 1)) begin
        cyc       <= 15'h0000;
        led_drive <= 1'b0;
      end else if (led_last) begin
        cyc       <= 15'h0000;
        led_drive <= 1'b1;
        pulses    <= pulses + 8'h01;
      end
    end else if (unit_end) begin
      cyc   <= 15'h0000;
      units <= units + 12'h001;
    end else begin
      cyc <= cyc + 15'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      proximity_result <= {`PXS_RST_ZERO, `PXS_RST_ZERO};
      persist_cnt      <= 4'h0;
    end else if (adc_done) begin
      proximity_result <= adc_result;
      if (!oor) persist_cnt <= 4'h0;
      else if (persist_cnt != 4'hf) persist_cnt <= persist_cnt + 4'h1;
    end
  end

  // A new event in the cycle of a clear command wins over the clear.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_flag        <= 1'b0;
      saturation_flag <= 1'b0;
      result_valid    <= 1'b0;
      irq_n           <= 1'b1;
    end else begin
      if (irq_set) irq_flag <= 1'b1;
      else if (sf_clear) irq_flag <= 1'b0;
      if (st == PXS_ACCUM && adc_saturated) saturation_flag <= 1'b1;
      else if (sf_clear) saturation_flag <= 1'b0;
      if (adc_done) result_valid <= 1'b1;
      else if (!meas_en) result_valid <= 1'b0;
      irq_n <= !(irq_flag && function_enable[`PXS_BIT_IRQ_OE]);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_adc_end;
    st == PXS_ADC && seq_done;
  endsequence
  sequence s_leave(pxs_seq_t s);
    st == s ##1 st != s;
  endsequence

  property p_irq_pin;
    1 |=> irq_n == !($past(irq_flag) && $past(function_enable[`PXS_BIT_IRQ_OE]));
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq pin disagrees with flag and enable");
  property p_range;
    s_adc_end and (adc_result < low_limit) |=> $past(oor) && proximity_result < low_limit;
  endproperty
  a_range: assert property (p_range) else $error("low result not flagged");
  property p_low_first;
    s_adc_end and (low_limit > high_limit && adc_result >= low_limit) |-> !oor;
  endproperty
  a_low_first: assert property (p_low_first) else $error("high side used on inverted window");
  property p_persist;
    s_adc_end and !oor |=> persist_cnt == 4'h0 && !$rose(irq_flag);
  endproperty
  a_persist: assert property (p_persist) else $error("persistence count not restarted");
  property p_hold;
    irq_flag && !sf_clear |=> irq_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped without clear");
  property p_order;
    s_leave(PXS_ACCUM) |-> st == PXS_PWAIT || st == PXS_IDLE;
  endproperty
  a_order: assert property (p_order) else $error("accumulate not followed by fixed wait");
  property p_init_len;
    st == PXS_INIT && next_st == PXS_ACCUM |-> unit_end && units == 12'h000;
  endproperty
  a_init_len: assert property (p_init_len) else $error("init not one unit long");
  property p_irq_time;
    $rose(irq_flag) |-> $past(st) == PXS_ADC && $past(seq_done);
  endproperty
  a_irq_time: assert property (p_irq_time) else $error("irq not at convert end");
  property p_sai;
    s_adc_end and (irq_set && sleep_after_irq && osc_on && meas_en) |=> st == PXS_SLEEP;
  endproperty
  a_sai: assert property (p_sai) else $error("no sleep after irq");
  property p_wait_len;
    st == PXS_WAIT && next_st == PXS_IDLE && osc_on && meas_en |-> units == wait_units - 12'h001;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("wait length wrong");
  property p_sleep;
    st == PXS_SLEEP && !req_ev |=> st == PXS_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep) else $error("left sleep without command");
  property p_clear;
    sf_clear && !irq_set && st != PXS_ACCUM |=> !irq_flag && !saturation_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear command ignored");
  property p_reset;
    disable iff (1'b0) rst |=> adc_time_setting == `PXS_RST_TIME
      && wait_time_setting == `PXS_RST_TIME && function_enable == `PXS_RST_ZERO && !irq_flag;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
endmodule : pxs_top

// File: tb/pxs_host.sv
// Serial bus master model standing in for the host controller.
// Drives open-drain pull-downs only; the bench resolves both wires with pull-ups.
module pxs_host #(
  parameter logic [6:0] ADDR = 7'h4c
) (
  input  wire logic scl,
  input  wire logic sda,
  output      logic scl_pd,
  output      logic sda_pd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ack_ok = 1'b1;
  initial begin
    scl_pd = 1'b0;
    sda_pd = 1'b0;
  end
  // The device stretches the clock, so the wire is watched, not a timer alone.
  task automatic rise;
    scl_pd = 1'b0;
    for (int i = 0; i < 500 && scl !== 1'b1; i++) #100;
    #700;
  endtask : rise
  task automatic bit_x(input logic b, output logic r);
    sda_pd = !b;
    #600;
    rise();
    r = sda;
    scl_pd = 1'b1;
    #300;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic r);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, r);
  endtask : byte_x
  task automatic start;
    sda_pd = 1'b0;
    #300;
    rise();
    sda_pd = 1'b1;
    #600;
    scl_pd = 1'b1;
    #300;
  endtask : start
  task automatic stop;
    sda_pd = 1'b1;
    #300;
    rise();
    sda_pd = 1'b0;
    #1300;
  endtask : stop
  task automatic write(input logic [7:0] cmd, input logic [15:0] d, input int n);
    logic [7:0] q;
    logic       r;
    start();
    byte_x({ADDR, 1'b0}, 1'b1, q, r);
    ack_ok &= !r;
    byte_x(cmd, 1'b1, q, r);
    ack_ok &= !r;
    for (int i = 0; i < n; i++) begin
      byte_x(d[8*i+:8], 1'b1, q, r);
      ack_ok &= !r;
    end
    stop();
  endtask : write
  task automatic read(input int n, output logic [15:0] v);
    logic [7:0] q;
    logic       r;
    v = 16'h0000;
    start();
    byte_x({ADDR, 1'b1}, 1'b1, q, r);
    ack_ok &= !r;
    for (int i = 0; i < n; i++) begin
      byte_x(8'hff, i == n - 1, q, r);
      v[8*i+:8] = q;
    end
    stop();
  endtask : read
endmodule : pxs_host

// File: tb/testbench.sv
// Self-checking bench: a bus master model reaches the registers, the bench plays the converter.
// Assumes a short time unit of 20 system cycles so a cycle lasts some sixty clocks.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, link_clk = 0, rst = 1, adc_sat = 0;
  logic [15:0] adc_result = 16'h0000, v;
  logic        scl_o, scl_oe, sda_o, sda_oe, led_drive, adc_busy, irq_n, h_scl, h_sda;
  wire logic   scl_i = !(scl_oe | h_scl);
  wire logic   sda_i = !(sda_oe | h_sda);
  int          error_cnt = 0, total_checks = 0;
  always #50 sys_clk = !sys_clk;
  initial #3 forever #7.5 link_clk = !link_clk;
  pxs_top #(.UNIT_CYCLES(20)) pxs_top_inst (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .adc_result(adc_result), .adc_saturated(adc_sat),
    .led_drive(led_drive), .adc_busy(adc_busy), .irq_n(irq_n));
  pxs_host host_inst (.scl(scl_i), .sda(sda_i), .scl_pd(h_scl), .sda_pd(h_sda));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // Counts falling edges until led_drive (led set) or adc_busy reaches lvl.
  // The bound is wide enough for a long wait state between two conversions.
  task automatic wait_lvl(input logic led, input logic lvl, output int n);
    for (n = 0; n < 600 && (led ? led_drive : adc_busy) !== lvl; n++) @(negedge sys_clk);
    if (n == 600) begin
      chk(16'h0000, 16'h0001);
      tally_and_finish();
    end
  endtask : wait_lvl
  task automatic cycle_end;
    int n;
    wait_lvl(1'b0, 1'b1, n);
    wait_lvl(1'b0, 1'b0, n);
    repeat (3) @(negedge sys_clk);
  endtask : cycle_end
  task automatic rd1(input logic [7:0] cmd, input logic [7:0] exp);
    host_inst.write(cmd, 16'h0000, 0);
    host_inst.read(1, v);
    chk(v, {8'h00, exp});
  endtask : rd1
  task automatic sc_reset;
    logic [4:0] ofs[8] = '{5'h00, 5'h02, 5'h03, 5'h08, 5'h0c, 5'h0e, 5'h13, 5'h18};
    for (int i = 0; i < 8; i++) rd1({3'b100, ofs[i]}, (ofs[i] inside {2, 3}) ? 8'hff : 8'h00);
    rd1(8'h92, 8'h5a);
  endtask : sc_reset
  task automatic sc_limits;
    host_inst.write(8'ha8, 16'h0100, 2);
    host_inst.write(8'haa, 16'h0200, 2);
    host_inst.write(8'ha8, 16'h0000, 0);
    host_inst.read(2, v);
    chk(v, 16'h0100);
    host_inst.read(2, v);
    chk(v, 16'h0200);
    host_inst.write(8'h93, 16'h00ff, 1);
    host_inst.read(2, v);
    chk(v, 16'h0000);
  endtask : sc_limits
  task automatic sc_irq;
    @(negedge sys_clk) adc_result = 16'h0050;
    host_inst.write(8'h8c, 16'h0002, 1);
    host_inst.write(8'h80, 16'h0025, 1);
    cycle_end();
    chk(irq_n, 16'h0001);
    cycle_end();
    chk(irq_n, 16'h0000);
    @(negedge sys_clk) adc_result = 16'h0150;
    rd1(8'h93, 8'h21);
    chk(irq_n, 16'h0000);
    host_inst.write(8'ha8 | 8'h10, 16'h0000, 0);
    host_inst.read(2, v);
    chk(v, 16'h0150);
    host_inst.write(8'he5, 16'h0000, 0);
    cycle_end();
    chk(irq_n, 16'h0001);
  endtask : sc_irq
  task automatic sc_order;
    // The result sits above both limits; while the old window still stands it may
    // raise the irq, so a clear follows once the inverted window is in place.
    @(negedge sys_clk) adc_result = 16'h0350;
    host_inst.write(8'h89, 16'h0003, 1);
    host_inst.write(8'h8c, 16'h0000, 1);
    host_inst.write(8'he5, 16'h0000, 0);
    cycle_end();
    cycle_end();
    chk(irq_n, 16'h0001);
    host_inst.write(8'h80, 16'h0005, 1);
    @(negedge sys_clk) adc_result = 16'h0050;
    cycle_end();
    cycle_end();
    chk(irq_n, 16'h0001);
    rd1(8'h93, 8'h21);
  endtask : sc_order
  task automatic sc_sleep_wait;
    int n;
    @(negedge sys_clk) adc_result = 16'h0350;
    host_inst.write(8'ha2, 16'hfeff, 2);
    host_inst.write(8'h8d, 16'h0002, 1);
    host_inst.write(8'h80, 16'h000d, 1);
    wait_lvl(1'b0, 1'b1, n);
    wait_lvl(1'b0, 1'b0, n);
    wait_lvl(1'b0, 1'b1, n);
    // Twelve times two units of wait, then idle, init, a one-cycle accumulate and fixed wait.
    chk(16'(n), 16'h020a);
    host_inst.write(8'h8e, 16'h0001, 1);
    @(negedge sys_clk) adc_result = 16'h0050;
    adc_sat = 1'b1;
    host_inst.write(8'h80, 16'h0065, 1);
    wait_lvl(1'b1, 1'b0, n);
    wait_lvl(1'b1, 1'b1, n);
    wait_lvl(1'b1, 1'b0, n);
    chk(16'(n), 16'h0049);
    cycle_end();
    chk(irq_n, 16'h0000);
    for (n = 0; n < 300 && adc_busy !== 1'b1; n++) @(negedge sys_clk);
    chk(16'(n), 16'h012c);
    host_inst.write(8'h93, 16'h0000, 0);
    cycle_end();
    rd1(8'h93, 8'h61);
  endtask : sc_sleep_wait
  initial begin
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    repeat (10) @(negedge sys_clk);
    sc_reset();
    sc_limits();
    sc_irq();
    sc_order();
    sc_sleep_wait();
    chk(host_inst.ack_ok, 16'h0001);
    tally_and_finish();
  end
endmodule : testbench
